// ---- bridge_err_defines.svh ----
// register offsets, field positions and reset values of the error register bank
`ifndef BRIDGE_ERR_DEFINES_SVH
`define BRIDGE_ERR_DEFINES_SVH

`define BEER_ADDR_ENABLE_ONE 8'hc0
`define BEER_ADDR_DETECT_ONE 8'hc1
`define BEER_ADDR_ENABLE_TWO 8'hc4
`define BEER_ADDR_DETECT_TWO 8'hc5
`define BEER_ADDR_OPTION 8'hc6

`define BEER_RESET_ENABLE_ONE 8'h01
`define BEER_RESET_ENABLE_TWO 8'h00
`define BEER_RESET_OPTION 8'h00

`define BEER_EN1_TARGET_ABORT 7
`define BEER_EN1_TARGET_PERR 6
`define BEER_EN1_MEM_SELECT 5
`define BEER_EN1_MASTER_PERR 4
`define BEER_EN1_MEM_PARITY 2
`define BEER_EN1_MASTER_ABORT 1
`define BEER_EN1_PROC_BUS 0
`define BEER_EN2_CACHE_PARITY 4
`define BEER_EN2_FLASH_WRITE 0

`define BEER_DT1_SYSTEM_ERROR 7
`define BEER_DT1_TARGET_PERR 6
`define BEER_DT1_MEM_SELECT 5
`define BEER_DT1_ORIGIN 3
`define BEER_DT1_MEM_PARITY 2
`define BEER_DT1_CODE_ATTRIBUTES 0
`define BEER_DT1_CODE_EXTENDED 1
`define BEER_DT2_ADDR_INVALID 7
`define BEER_DT2_CACHE_PARITY 4
`define BEER_DT2_FLASH_WRITE 0

`define BEER_OPT_RX_SYSTEM_ERROR 5

`define BEER_MASK_ENABLE_ONE 8'hf7
`define BEER_MASK_ENABLE_TWO 8'h11
`define BEER_MASK_DETECT_ONE 8'hef
`define BEER_MASK_DETECT_TWO 8'h91
`define BEER_MASK_OPTION 8'h20
`define BEER_MASK_CAPTURED_ONE 8'h08
`define BEER_MASK_CAPTURED_TWO 8'h80

`define BEER_CYCLE_NONE 2'h0
`define BEER_CYCLE_ATTRIBUTES 2'h1
`define BEER_CYCLE_EXTENDED 2'h2

`endif

// ---- beer_pkg.sv ----
// types of the error enable and detection register bank
`default_nettype none
package beer_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } beer_bus_s;

   typedef struct packed {
      logic systemErrorOwn;
      logic systemErrorOther;
      logic targetPerr;
      logic memSelect;
      logic masterPerr;
      logic memParity;
      logic targetAbort;
      logic masterAbort;
      logic cycleAttributes;
      logic cycleExtended;
      logic cacheParity;
      logic flashWrite;
      logic fromPci;
      logic addrValid;
   } beer_events_s;

endpackage
`default_nettype wire

// ---- beer_regs.sv ----
// error enable and error detection register bank
`timescale 1ns/100ps
`default_nettype none
`include "bridge_err_defines.svh"

// Operation
// RQ1: each condition is recognised and reported only while its enable bit is set; own system error sets detect-one bit 7 and reports with no enable bit
// RQ2: enable-one bit 7 gates received target aborts as master, resets zero
// RQ3: enable-one bit 6 gates parity errors as target
// RQ4: enable-one bit 5 gates memory select errors
// RQ5: enable-one bit 4 gates parity errors as master
// RQ6: enable-one bit 2 gates memory read parity errors
// RQ7: enable-one bit 1 gates master aborts as master
// RQ8: enable-one bit 0 gates processor bus errors, resets to one
// RQ9: enable-two bit 4 enables secondary-cache parity detection, resets zero
// RQ10: enable-two bit 0 enables flash write error reporting, resets zero
// RQ11: detect reads return flags; writing one clears a flag; writes never set
// RQ12: an enabled detected error sets its flag
// RQ13: later errors set flags but capture freezes until all flags clear
// RQ14: detect-one bit 7 flags system error; others' only with option bit 5
// RQ15: detect-one bit 6 set when bridge as target signalled parity error
// RQ16: detect-one bit 5 set on memory select error
// RQ17: detect-one bit 3 records origin: zero processor, one PCI
// RQ18: detect-one bit 2 set on memory read parity error
// RQ19: detect-one bits 1:0 encode unsupported processor cycle type
// RQ20: detect-two bit 7 reads one when captured address is invalid
// RQ21: detect-two bit 4 set on secondary-cache parity error
// RQ22: detect-two bit 0 set on flash write while flash writes disabled
// RQ23: reserved bits read zero and ignore writes
module beer_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire beer_pkg::beer_bus_s bus,
   output logic [7:0] rdata,
   input wire beer_pkg::beer_events_s events,
   output logic captureEnable,
   output logic reportedError,
   output logic receiveSystemErrorEnable
);
   import beer_pkg::*;

   logic [7:0] errorEnableOne;
   logic [7:0] errorEnableTwo;
   logic [7:0] errorDetectOne;
   logic [7:0] errorDetectTwo;
   logic [7:0] optionReg;
   logic [7:0] next_rdata;
   logic [7:0] setOne;
   logic [7:0] setTwo;
   logic [7:0] clearOne;
   logic [7:0] clearTwo;
   logic [7:0] next_detectOne;
   logic [7:0] next_detectTwo;
   logic anyEvent;
   logic flagsClear;

   logic wrEnOne;
   logic wrEnTwo;
   logic wrDetOne;
   logic wrDetTwo;
   logic wrOption;

   assign wrEnOne = bus.write && (bus.addr == `BEER_ADDR_ENABLE_ONE);
   assign wrEnTwo = bus.write && (bus.addr == `BEER_ADDR_ENABLE_TWO);
   assign wrDetOne = bus.write && (bus.addr == `BEER_ADDR_DETECT_ONE);
   assign wrDetTwo = bus.write && (bus.addr == `BEER_ADDR_DETECT_TWO);
   assign wrOption = bus.write && (bus.addr == `BEER_ADDR_OPTION);

   // enable registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         errorEnableOne <= `BEER_RESET_ENABLE_ONE; // RQ2 RQ8
      end else if (wrEnOne) begin
         errorEnableOne <= bus.wdata & `BEER_MASK_ENABLE_ONE; // RQ23
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         errorEnableTwo <= `BEER_RESET_ENABLE_TWO; // RQ9 RQ10
      end else if (wrEnTwo) begin
         errorEnableTwo <= bus.wdata & `BEER_MASK_ENABLE_TWO; // RQ23
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         optionReg <= `BEER_RESET_OPTION;
      end else if (wrOption) begin
         optionReg <= bus.wdata & `BEER_MASK_OPTION;
      end
   end

   // gated event sets
   always_comb begin
      setOne = 8'h00;
      setTwo = 8'h00;
      setOne[`BEER_DT1_SYSTEM_ERROR] = events.systemErrorOwn
         || (events.systemErrorOther && optionReg[`BEER_OPT_RX_SYSTEM_ERROR]); // RQ14
      setOne[`BEER_DT1_TARGET_PERR] = events.targetPerr
         && errorEnableOne[`BEER_EN1_TARGET_PERR]; // RQ3 RQ15
      setOne[`BEER_DT1_MEM_SELECT] = events.memSelect
         && errorEnableOne[`BEER_EN1_MEM_SELECT]; // RQ4 RQ16
      setOne[`BEER_DT1_MEM_PARITY] = events.memParity
         && errorEnableOne[`BEER_EN1_MEM_PARITY]; // RQ6 RQ18
      setOne[`BEER_DT1_CODE_ATTRIBUTES] = events.cycleAttributes
         && errorEnableOne[`BEER_EN1_PROC_BUS]; // RQ8 RQ19
      setOne[`BEER_DT1_CODE_EXTENDED] = events.cycleExtended
         && errorEnableOne[`BEER_EN1_PROC_BUS]; // RQ8 RQ19
      setTwo[`BEER_DT2_CACHE_PARITY] = events.cacheParity
         && errorEnableTwo[`BEER_EN2_CACHE_PARITY]; // RQ9 RQ21
      setTwo[`BEER_DT2_FLASH_WRITE] = events.flashWrite
         && errorEnableTwo[`BEER_EN2_FLASH_WRITE]; // RQ10 RQ22
   end

   // master-side conditions have no flag here, only the report output
   assign anyEvent = (|setOne) || (|setTwo)
      || (events.masterPerr && errorEnableOne[`BEER_EN1_MASTER_PERR]) // RQ5
      || (events.targetAbort && errorEnableOne[`BEER_EN1_TARGET_ABORT]) // RQ2
      || (events.masterAbort && errorEnableOne[`BEER_EN1_MASTER_ABORT]); // RQ7 RQ1

   assign flagsClear = ((errorDetectOne & ~`BEER_MASK_CAPTURED_ONE) == 8'h00)
      && ((errorDetectTwo & ~`BEER_MASK_CAPTURED_TWO) == 8'h00);

   assign clearOne = wrDetOne ? bus.wdata : 8'h00;
   assign clearTwo = wrDetTwo ? bus.wdata : 8'h00;

   // set wins over clear on the same cycle
   always_comb begin
      next_detectOne = ((errorDetectOne & ~clearOne) | setOne) & `BEER_MASK_DETECT_ONE; // RQ11
      next_detectTwo = ((errorDetectTwo & ~clearTwo) | setTwo) & `BEER_MASK_DETECT_TWO; // RQ11
      // two-bit cycle code: extended wins if both arrive at once
      if (setOne[`BEER_DT1_CODE_EXTENDED]) begin
         next_detectOne[`BEER_DT1_CODE_ATTRIBUTES] = 1'b0; // RQ19
      end
      // origin and address validity are captured, not w1c, only when capture is open
      next_detectOne[`BEER_DT1_ORIGIN] = errorDetectOne[`BEER_DT1_ORIGIN];
      next_detectTwo[`BEER_DT2_ADDR_INVALID] = errorDetectTwo[`BEER_DT2_ADDR_INVALID];
      if ((|setOne || |setTwo) && flagsClear) begin
         next_detectOne[`BEER_DT1_ORIGIN] = events.fromPci; // RQ17 RQ13
         next_detectTwo[`BEER_DT2_ADDR_INVALID] = !events.addrValid; // RQ20 RQ13
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         errorDetectOne <= 8'h00;
      end else begin
         errorDetectOne <= next_detectOne; // RQ12
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         errorDetectTwo <= 8'h00;
      end else begin
         errorDetectTwo <= next_detectTwo; // RQ12
      end
   end

   // capture window open only while no flag is set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         captureEnable <= 1'b1;
      end else begin
         captureEnable <= ((next_detectOne & ~`BEER_MASK_CAPTURED_ONE) == 8'h00)
            && ((next_detectTwo & ~`BEER_MASK_CAPTURED_TWO) == 8'h00); // RQ13
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reportedError <= 1'b0;
      end else begin
         reportedError <= anyEvent; // RQ1
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         receiveSystemErrorEnable <= 1'b0;
      end else begin
         receiveSystemErrorEnable <= (wrOption ? bus.wdata[`BEER_OPT_RX_SYSTEM_ERROR]
            : optionReg[`BEER_OPT_RX_SYSTEM_ERROR]);
      end
   end

   // read mux
   always_comb begin
      case (bus.addr)
         `BEER_ADDR_ENABLE_ONE: next_rdata = errorEnableOne;
         `BEER_ADDR_DETECT_ONE: next_rdata = errorDetectOne; // RQ11
         `BEER_ADDR_ENABLE_TWO: next_rdata = errorEnableTwo;
         `BEER_ADDR_DETECT_TWO: next_rdata = errorDetectTwo;
         `BEER_ADDR_OPTION: next_rdata = optionReg;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else if (bus.read) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// ---- beer_regs_chk.sv ----
// port assertions for the error register bank
`timescale 1ns/100ps
`default_nettype none
module beer_regs_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire beer_pkg::beer_bus_s bus,
   input wire logic [7:0] rdata,
   input wire beer_pkg::beer_events_s events,
   input wire logic captureEnable,
   input wire logic reportedError,
   input wire logic receiveSystemErrorEnable
);
   import beer_pkg::*;
   logic anyErr;
   logic optWr;
   assign anyErr = |events[13:2];
   assign optWr = bus.write && bus.addr == 8'hc6;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   AST_RDATA_IDLE: assert property (!$past(bus.read) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_REPORT_CAUSE: assert property (reportedError |-> $past(anyErr))
      else $error("report without an error pulse");
   AST_CAP_FALL: assert property ($fell(captureEnable) |-> $past(anyErr))
      else $error("capture closed without an error pulse");
   AST_CAP_RISE: assert property ($rose(captureEnable) |-> $past(bus.write))
      else $error("capture reopened without a write");
   AST_CAP_HOLD: assert property (!captureEnable && !bus.write |=> !captureEnable)
      else $error("capture reopened while flags stand");
   AST_RSE_FOLLOW: assert property (optWr |=> receiveSystemErrorEnable == $past(bus.wdata[5]))
      else $error("receive enable not taken from write");
   AST_RSE_STABLE: assert property (!optWr |=> $stable(receiveSystemErrorEnable))
      else $error("receive enable changed without write");
   AST_SERR_OWN: assert property (events.systemErrorOwn |=> !captureEnable)
      else $error("own system error did not close capture");
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the error register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import beer_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   beer_bus_s bus = '0;
   beer_events_s events = '0;
   logic [7:0] rdata;
   logic captureEnable, reportedError, receiveSystemErrorEnable;
   int fails = 0;
   int samples_checked = 0;
   beer_regs u_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .events(events),
      .captureEnable(captureEnable), .reportedError(reportedError),
      .receiveSystemErrorEnable(receiveSystemErrorEnable));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.read <= 1'b0;
      @(negedge clk);
      chk("rdata", rdata, exp);
   endtask
   task automatic pulse(input beer_events_s e);
      @(posedge clk);
      events <= e;
      @(posedge clk);
      events <= '0;
      @(negedge clk);
   endtask
   task automatic t_reset;
      rd(8'hc0, 8'h01);
      rd(8'hc4, 8'h00);
      rd(8'hc5, 8'h00);
      chk("cap", {7'h0, captureEnable}, 8'h01);
      wr(8'hc0, 8'hff);
      rd(8'hc0, 8'hf7);
      wr(8'hc4, 8'hff);
      rd(8'hc4, 8'h11);
      wr(8'hc2, 8'hff);
      rd(8'hc2, 8'h00);
      wr(8'hc1, 8'hff);
      rd(8'hc1, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_gate;
      int ev [10] = '{11, 10, 8, 5, 4, 3, 2, 7, 6, 9};
      logic [7:0] en [10] = '{8'h40, 8'h20, 8'h04, 8'h01, 8'h01, 8'h10, 8'h01, 8'h80, 8'h02, 8'h10};
      logic [7:0] dt [10] = '{8'h40, 8'h20, 8'h04, 8'h01, 8'h02, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00};
      logic [7:0] ea;
      beer_events_s e;
      for (int k = 0; k < 10; k++) begin
         ea = (k == 5 || k == 6) ? 8'hc4 : 8'hc0;
         e = 14'h0001;
         e[ev[k]] = 1'b1;
         wr(8'hc0, 8'h00);
         wr(8'hc4, 8'h00);
         pulse(e);
         chk("rep", {7'h0, reportedError}, 8'h00);
         rd(ea + 8'h01, 8'h00);
         wr(ea, en[k]);
         pulse(e);
         chk("rep", {7'h0, reportedError}, 8'h01);
         chk("cap", {7'h0, captureEnable}, {7'h0, dt[k] == 8'h00});
         rd(ea + 8'h01, dt[k]);
         wr(ea + 8'h01, 8'hff);
         rd(ea + 8'h01, 8'h00);
      end
      $display("test gate done");
   endtask
   task automatic t_serr;
      pulse(14'h1001);
      chk("rep", {7'h0, reportedError}, 8'h00);
      rd(8'hc1, 8'h00);
      wr(8'hc6, 8'h20);
      rd(8'hc6, 8'h20);
      chk("rse", {7'h0, receiveSystemErrorEnable}, 8'h01);
      pulse(14'h1002);
      chk("rep", {7'h0, reportedError}, 8'h01);
      rd(8'hc1, 8'h88);
      rd(8'hc5, 8'h80);
      wr(8'hc0, 8'h21);
      pulse(14'h0401);
      wr(8'hc1, 8'h00);
      rd(8'hc1, 8'ha8);
      wr(8'hc1, 8'h20);
      rd(8'hc1, 8'h88);
      chk("cap", {7'h0, captureEnable}, 8'h00);
      wr(8'hc1, 8'h80);
      rd(8'hc4, 8'h00);
      chk("cap", {7'h0, captureEnable}, 8'h01);
      wr(8'hc6, 8'h00);
      pulse(14'h2001);
      rd(8'hc1, 8'h80);
      chk("rse", {7'h0, receiveSystemErrorEnable}, 8'h00);
      wr(8'hc1, 8'hff);
      pulse(14'h0031);
      rd(8'hc1, 8'h02);
      $display("test serr done");
   endtask
   task automatic t_rerun;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk("cap", {7'h0, captureEnable}, 8'h01);
      chk("rse", {7'h0, receiveSystemErrorEnable}, 8'h00);
      rd(8'hc0, 8'h01);
      rd(8'hc1, 8'h00);
      rd(8'hc4, 8'h00);
      $display("test rerun done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_gate();
      t_serr();
      t_rerun();
      tally_and_finish();
   end
endmodule
bind beer_regs beer_regs_chk u_chk (.clk, .reset_n, .bus, .rdata, .events, .captureEnable,
   .reportedError, .receiveSystemErrorEnable);
`default_nettype wire
